//--- core/dmm_monitor_map.sv
/*
 * Diagnostic monitoring map: latched lane flags, module temperature and
 * supply voltage words, read by the host over the two-wire serial pins.
 * Assumes measurements and thresholds come from logic on mclk; scl and sda
 * come from the pins and are synchronised here. The board pulls sda up.
 */
`timescale 1ns/1ps
`default_nettype none

module dmm_monitor_map
    import dmm_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    output var  logic                  sda_out,
    output var  logic                  sda_oe,
    input  wire logic [3:0][15:0]      rx_power,
    input  wire logic [3:0][15:0]      tx_bias,
    input  wire dmm_thr_s              rx_thr,
    input  wire dmm_thr_s              tx_thr,
    input  wire dmm_mod_s              mod_meas,
    input  wire logic                  mod_meas_valid
);

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // direct compare works because thresholds share the word encoding
    function automatic logic [3:0] thr_cmp(input logic [15:0] m, input dmm_thr_s t);
        thr_cmp = {m > t.hi_alarm, m < t.lo_alarm, m > t.hi_warn, m < t.lo_warn};
    endfunction
    // one-hot select of the flag byte at an offset
    function automatic logic [3:0] flag_sel(input logic [7:0] ofs);
        case (ofs)
            OFS_RX_FLAGS12: flag_sel = 4'h1;
            OFS_RX_FLAGS34: flag_sel = 4'h2;
            OFS_TX_FLAGS12: flag_sel = 4'h4;
            OFS_TX_FLAGS34: flag_sel = 4'h8;
            default:        flag_sel = 4'h0;
        endcase
    endfunction
    // byte presented to the host; reserved and vendor bytes read zero
    function automatic logic [7:0] map_byte(input logic [7:0] ofs, input logic [31:0] fl, input dmm_mod_s w);
        case (ofs)
            OFS_RX_FLAGS12: map_byte = fl[7:0];
            OFS_RX_FLAGS34: map_byte = fl[15:8];
            OFS_TX_FLAGS12: map_byte = fl[23:16];
            OFS_TX_FLAGS34: map_byte = fl[31:24];
            OFS_TEMP_MSB:   map_byte = w.temp[15:8];
            OFS_TEMP_LSB:   map_byte = w.temp[7:0];
            OFS_VOLT_MSB:   map_byte = w.volt[15:8];
            OFS_VOLT_LSB:   map_byte = w.volt[7:0];
            default:        map_byte = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and bus events
    // ------------------------------------------------------------
    logic [1:0]  scl_sync_reg;
    logic [1:0]  sda_sync_reg;
    logic        scl_prev_reg;
    logic        sda_prev_reg;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;
    // idle bus level is high, so reset to one avoids a false start
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], scl_in};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end
    // edges and start/stop seen only on the second-stage samples
    assign scl_rise  = scl_sync_reg[1] & ~scl_prev_reg;
    assign scl_fall  = ~scl_sync_reg[1] & scl_prev_reg;
    assign bus_start = scl_sync_reg[1] & scl_prev_reg & sda_prev_reg & ~sda_sync_reg[1];
    assign bus_stop  = scl_sync_reg[1] & scl_prev_reg & ~sda_prev_reg & sda_sync_reg[1];

    // ------------------------------------------------------------
    // threshold conditions per lane
    // ------------------------------------------------------------
    logic [31:0] cond;
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        localparam int RXB  = l / 2;
        localparam int TXB  = 2 + l / 2;
        localparam int BASE = (l % 2 == 0) ? 4 : 0;
        assign cond[RXB*8+BASE +: 4] = thr_cmp(rx_power[l], rx_thr);
        assign cond[TXB*8+BASE +: 4] = thr_cmp(tx_bias[l], tx_thr);
    end

    // ------------------------------------------------------------
    // latched flags
    // ------------------------------------------------------------
    logic [31:0] flags_reg;
    logic [31:0] flags_next;
    logic [3:0]  clr_pulse_reg;
    // a live condition always wins over the read clear
    always_comb
    begin
        flags_next = flags_reg | cond;
        for (int k = 0; k < 4; k++)
        begin
            if (clr_pulse_reg[k])
                flags_next[k*8 +: 8] = cond[k*8 +: 8];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            flags_reg <= FLAG_RESET;
        else
            flags_reg <= flags_next;
    end

    // ------------------------------------------------------------
    // module words with deferred update
    // ------------------------------------------------------------
    dmm_mod_s    word_reg;
    dmm_mod_s    pend_reg;
    logic        pend_valid_reg;
    logic        busy_reg;
    // a new sample waits while a transaction runs, so a two-byte read
    // never straddles an update; long transactions delay the update
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            word_reg       <= {WORD_RESET, WORD_RESET};
            pend_reg       <= {WORD_RESET, WORD_RESET};
            pend_valid_reg <= 1'b0;
        end
        else
        begin
            if (pend_valid_reg && !busy_reg)
            begin
                word_reg       <= pend_reg;
                pend_valid_reg <= 1'b0;
            end
            if (mod_meas_valid)
            begin
                pend_reg.temp  <= mod_meas.temp & TEMP_KEEP_MASK;
                pend_reg.volt  <= mod_meas.volt & VOLT_KEEP_MASK;
                pend_valid_reg <= 1'b1;
            end
        end
    end

    // transaction window from start to stop
    always_ff @(posedge mclk)
    begin
        if (rst)
            busy_reg <= 1'b0;
        else if (bus_start)
            busy_reg <= 1'b1;
        else if (bus_stop)
            busy_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // serial protocol
    // ------------------------------------------------------------
    dmm_state_e  state_reg;
    logic [3:0]  cnt_reg;
    logic [7:0]  sh_reg;
    logic [7:0]  tx_reg;
    logic [7:0]  ptr_reg;
    logic [7:0]  load_byte;
    logic        rw_reg;
    logic        first_reg;
    logic        sda_oe_reg;
    assign load_byte = map_byte(ptr_reg, flags_reg, word_reg);
    // sda only ever pulled low; release lets the pull-up show a one
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 4'h0;
            sh_reg        <= 8'h00;
            tx_reg        <= 8'h00;
            ptr_reg       <= 8'h00;
            rw_reg        <= 1'b0;
            first_reg     <= 1'b0;
            sda_oe_reg    <= 1'b0;
            clr_pulse_reg <= 4'h0;
        end
        else
        begin
            clr_pulse_reg <= 4'h0;
            if (bus_start)
            begin
                state_reg  <= ST_ADDR;
                cnt_reg    <= 4'h0;
                sda_oe_reg <= 1'b0;
            end
            else if (bus_stop)
            begin
                state_reg  <= ST_IDLE;
                sda_oe_reg <= 1'b0;
            end
            else
            begin
                case (state_reg)
                    ST_ADDR, ST_WR:
                    begin
                        if (scl_rise)
                        begin
                            sh_reg  <= {sh_reg[6:0], sda_sync_reg[1]};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                        else if (scl_fall && cnt_reg == BIT_COUNT)
                        begin
                            cnt_reg <= 4'h0;
                            if (state_reg == ST_WR)
                            begin
                                sda_oe_reg <= 1'b1;
                                state_reg  <= ST_ACK_W;
                                first_reg  <= 1'b0;
                                if (first_reg)
                                    ptr_reg <= sh_reg; // later written bytes are acked, dropped
                            end
                            else if (sh_reg[7:1] == DEV_ADDR)
                            begin
                                rw_reg     <= sh_reg[0];
                                sda_oe_reg <= 1'b1;
                                state_reg  <= ST_ACK_A;
                            end
                            else
                                state_reg <= ST_IDLE;
                        end
                    end
                    ST_ACK_A:
                    begin
                        if (scl_fall && rw_reg)
                        begin
                            tx_reg     <= {load_byte[6:0], 1'b0};
                            sda_oe_reg <= ~load_byte[7];
                            cnt_reg    <= 4'h1;
                            state_reg  <= ST_RD;
                        end
                        else if (scl_fall)
                        begin
                            sda_oe_reg <= 1'b0;
                            first_reg  <= 1'b1;
                            cnt_reg    <= 4'h0;
                            state_reg  <= ST_WR;
                        end
                    end
                    ST_ACK_W:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_reg <= 1'b0;
                            state_reg  <= ST_WR;
                        end
                    end
                    ST_RD:
                    begin
                        if (scl_fall && cnt_reg == BIT_COUNT)
                        begin
                            sda_oe_reg    <= 1'b0;
                            clr_pulse_reg <= flag_sel(ptr_reg);
                            ptr_reg       <= ptr_reg + 8'h01;
                            state_reg     <= ST_RACK;
                        end
                        else if (scl_fall)
                        begin
                            sda_oe_reg <= ~tx_reg[7];
                            tx_reg     <= {tx_reg[6:0], 1'b0};
                            cnt_reg    <= cnt_reg + 4'h1;
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_rise)
                            state_reg <= sda_sync_reg[1] ? ST_IDLE : ST_ACK_A;
                    end
                    default:
                        state_reg <= ST_IDLE;
                endcase
            end
        end
    end
    assign sda_oe  = sda_oe_reg;
    assign sda_out = 1'b0 & sda_oe_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_last_bit;
        state_reg == ST_RD && scl_fall && cnt_reg == BIT_COUNT;
    endsequence
    sequence s_load(logic [7:0] ofs);
        state_reg == ST_ACK_A && scl_fall && rw_reg && ptr_reg == ofs;
    endsequence
    chk_flag_sticky: assert property (clr_pulse_reg == 4'h0 |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
        else $error("latched flag dropped without a read");
    chk_flag_set_cond: assert property (1'b1 |=> (flags_reg & $past(cond)) == $past(cond))
        else $error("crossing did not set its flag");
    chk_read_clears: assert property (clr_pulse_reg[0] |=> flags_reg[7:0] == $past(cond[7:0]))
        else $error("read of flag byte did not clear to live conditions");
    chk_read_strobe: assert property (s_last_bit |=> clr_pulse_reg == flag_sel($past(ptr_reg)) ##1 clr_pulse_reg == 4'h0)
        else $error("clear strobe wrong after byte read");
    chk_word_hold: assert property ($past(busy_reg) |-> $stable(word_reg))
        else $error("module word changed during a transaction");
    chk_pend_apply: assert property (pend_valid_reg && !busy_reg |=> word_reg == $past(pend_reg))
        else $error("pending sample not applied when bus idle");
    chk_low_bits: assert property (mod_meas_valid |=>
        pend_reg == ($past(mod_meas) & {TEMP_KEEP_MASK, VOLT_KEEP_MASK}))
        else $error("sample not captured with low bits masked");
    chk_temp_msb_map: assert property (s_load(OFS_TEMP_MSB) |=> sda_oe_reg == ~$past(word_reg.temp[15]) && tx_reg == {$past(word_reg.temp[14:8]), 1'b0})
        else $error("temperature high byte misplaced");
    chk_volt_lsb_map: assert property (s_load(OFS_VOLT_LSB) |=> tx_reg == {$past(word_reg.volt[6:0]), 1'b0})
        else $error("voltage low byte misplaced");
    chk_rx_flag_map: assert property (s_load(OFS_RX_FLAGS12) |=> tx_reg == {$past(flags_reg[6:0]), 1'b0})
        else $error("flag byte 9 misplaced");

endmodule // dmm_monitor_map

`default_nettype wire

//--- core/dmm_pkg.sv
/*
 * Constants, types and address map for the diagnostic monitoring map.
 * Assumes one 50 MHz management clock and a host on the two-wire serial pins.
 */
// What this block does
// - byte 9 holds latched optical input flags, lane 1 high nibble, lane 2 low
// - byte 10 holds latched optical input flags, lane 3 high nibble, lane 4 low
// - byte 11 holds latched laser current flags, lane 1 high nibble, lane 2 low
// - byte 12 holds latched laser current flags, lane 3 high nibble, lane 4 low
// - each measured value is a 16-bit word, high byte at lower address
// - low-order bits past real accuracy should read as zero; both keep masks are 16'hFFFF, so no bits are cleared
// - words update atomically and never while being transferred
// - temperature is signed two's complement, 1/256 degree per count
// - supply voltage is unsigned, 100 microvolts per count
// - thresholds share the encoding of their measurement and compare directly
// - temperature at bytes 22 and 23, bytes 24 and 25 reserved
// - voltage at bytes 26 and 27, 28 to 33 reserved or vendor space
`default_nettype none

package dmm_pkg;

    // ------------------------------------------------------------
    // bus address and byte map
    // ------------------------------------------------------------
    localparam logic [6:0]  DEV_ADDR       = 7'h50;
    localparam logic [7:0]  OFS_RX_FLAGS12 = 8'h09;
    localparam logic [7:0]  OFS_RX_FLAGS34 = 8'h0A;
    localparam logic [7:0]  OFS_TX_FLAGS12 = 8'h0B;
    localparam logic [7:0]  OFS_TX_FLAGS34 = 8'h0C;
    localparam logic [7:0]  OFS_TEMP_MSB   = 8'h16;
    localparam logic [7:0]  OFS_TEMP_LSB   = 8'h17;
    localparam logic [7:0]  OFS_VOLT_MSB   = 8'h1A;
    localparam logic [7:0]  OFS_VOLT_LSB   = 8'h1B;

    // ------------------------------------------------------------
    // reset values, masks and counts
    // ------------------------------------------------------------
    localparam logic [31:0] FLAG_RESET     = 32'h0000_0000;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [15:0] TEMP_KEEP_MASK = 16'hFFFF; // keeps every bit, none past sensor accuracy are cleared
    localparam logic [15:0] VOLT_KEEP_MASK = 16'hFFFF;
    localparam logic [3:0]  BIT_COUNT      = 4'h8;
    localparam int          LANES          = 4;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] hi_alarm;
        logic [15:0] lo_alarm;
        logic [15:0] hi_warn;
        logic [15:0] lo_warn;
    } dmm_thr_s;

    typedef struct packed {
        logic signed [15:0] temp;
        logic [15:0]        volt;
    } dmm_mod_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_ACK_A = 3'b010,
        ST_WR    = 3'b011,
        ST_ACK_W = 3'b100,
        ST_RD    = 3'b101,
        ST_RACK  = 3'b110
    } dmm_state_e;

endpackage

`default_nettype wire

//--- testbench/dmm_host_model.sv
/*
 * Host controller model for the two-wire serial management pins.
 * Assumes the bench resolves the sda wire (pull-up, open drain) and feeds
 * it back on sda_line; all pin changes land on falling mclk edges.
 */
`timescale 1ns/1ps
`default_nettype none

module dmm_host_model (
    input  wire logic mclk,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda_low
);
    // ------------------------------------------------------------
    // transaction results seen by the bench
    // ------------------------------------------------------------
    logic [7:0] rd_buf [16];
    logic [2:0] acks;
    int         got_n;

    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
        got_n   = 0;
    end

    // ------------------------------------------------------------
    // bit and byte level, 8 mclk per bit: 5 low, 3 high
    // ------------------------------------------------------------
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // data changes only while scl is low, sampled mid high phase
    task automatic xfer_bit(input logic b, output logic r);
        w(2);
        sda_low = ~b;
        w(3);
        scl = 1'b1;
        w(2);
        r = sda_line;
        w(1);
        scl = 1'b0;
    endtask

    // long release first: the device may still hold its ack low
    task automatic start_cond();
        sda_low = 1'b0;
        w(6);
        scl = 1'b1;
        w(4);
        sda_low = 1'b1;
        w(5);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        sda_low = 1'b1;
        w(5);
        scl = 1'b1;
        w(4);
        sda_low = 1'b0;
        w(6);
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], r);
        xfer_bit(1'b1, ack);
    endtask

    // host ack keeps the read going, nack on the last byte ends it
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(1'b1, d[i]);
        xfer_bit(last, r);
    endtask

    // ------------------------------------------------------------
    // pointer write, repeated start, then n bytes in one transfer
    // ------------------------------------------------------------
    task automatic read_seq(input logic [6:0] dev, input logic [7:0] ofs, input int n);
        got_n = 0;
        acks  = 3'b111;
        start_cond();
        put_byte({dev, 1'b0}, acks[0]);
        if (acks[0] === 1'b0)
        begin
            put_byte(ofs, acks[1]);
            start_cond();
            put_byte({dev, 1'b1}, acks[2]);
            // a word never split over two transactions
            for (int i = 0; i < n; i++)
            begin
                get_byte(i == n - 1, rd_buf[i]);
                got_n = i + 1;
            end
        end
        stop_cond();
    endtask

endmodule // dmm_host_model

`default_nettype wire

//--- testbench/dmm_monitor_map_tb.sv
/*
 * Self-checking bench for the diagnostic monitoring map.
 * Assumes the host model drives the pins and a pull-up on sda.
 */
`timescale 1ns/1ps
`default_nettype none

`define DMM_CHK(got, exp) \
    begin \
        checks_done++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("Error at %0t: read %h expected %h", $time, got, exp); \
        end \
    end

module dmm_monitor_map_tb;
    import dmm_pkg::*;

    logic             mclk;
    logic             rst;
    logic             scl;
    logic             sda_low;
    logic             sda_line;
    logic             sda_out;
    logic             sda_oe;
    logic [3:0][15:0] rx_power;
    logic [3:0][15:0] tx_bias;
    dmm_thr_s         thr;
    dmm_thr_s         tx_thr;
    dmm_mod_s         mod_meas;
    logic             mod_meas_valid;
    int               num_errors;
    int               checks_done;

    // ------------------------------------------------------------
    // clock, open-drain wire, instances
    // ------------------------------------------------------------
    always #10 mclk = ~mclk;

    // pull-up unless either party pulls low
    assign sda_line = (sda_oe ? sda_out : 1'b1) & ~sda_low;

    dmm_monitor_map dmm_monitor_map_inst (
        .mclk           (mclk),
        .rst            (rst),
        .scl_in         (scl),
        .sda_in         (sda_line),
        .sda_out        (sda_out),
        .sda_oe         (sda_oe),
        .rx_power       (rx_power),
        .tx_bias        (tx_bias),
        .rx_thr         (thr),
        .tx_thr         (tx_thr),
        .mod_meas       (mod_meas),
        .mod_meas_valid (mod_meas_valid)
    );

    dmm_host_model host_inst (
        .mclk     (mclk),
        .sda_line (sda_line),
        .scl      (scl),
        .sda_low  (sda_low)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic results();
        if (num_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // read n bytes from ofs, compare against e, left aligned
    task automatic chk_bytes(input logic [7:0] ofs, input int n, input logic [95:0] e);
        host_inst.read_seq(DEV_ADDR, ofs, n);
        `DMM_CHK(host_inst.acks, 3'b000)
        for (int k = 0; k < n; k++)
            `DMM_CHK(host_inst.rd_buf[k], e[95 - 8 * k -: 8])
    endtask

    task automatic pulse_meas(input logic [31:0] v);
        mod_meas       = v;
        mod_meas_valid = 1'b1;
        @(negedge mclk);
        mod_meas_valid = 1'b0;
    endtask

    // all lanes back inside limits, then let the latches settle
    task automatic lanes_ok();
        rx_power = {4{16'd500}};
        tx_bias  = {4{16'd500}};
        repeat (4) @(negedge mclk);
    endtask

    // ------------------------------------------------------------
    // watchdog: whole run needs about 5800 cycles
    // ------------------------------------------------------------
    initial
    begin
        repeat (40000) @(negedge mclk);
        num_errors++;
        results();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        mclk           = 1'b0;
        rst            = 1'b1;
        num_errors     = 0;
        checks_done    = 0;
        rx_power       = {4{16'd500}};
        tx_bias        = {4{16'd500}};
        thr            = {16'd1000, 16'd100, 16'd800, 16'd200};
        // separate laser current limits catch a swapped threshold set
        tx_thr         = {16'd1400, 16'd50, 16'd900, 16'd150};
        mod_meas       = 32'h0;
        mod_meas_valid = 1'b0;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        chk_bytes(OFS_RX_FLAGS12, 4, {32'h0, 64'h0});
        // wrong device address is not acknowledged
        host_inst.read_seq(7'h51, OFS_TEMP_MSB, 1);
        `DMM_CHK(host_inst.acks[0], 1'b1)
        // negative temperature, reserved and vendor bytes read zero
        pulse_meas(32'hE780_8235);
        chk_bytes(OFS_TEMP_MSB, 12, {48'hE780_0000_8235, 48'h0});
        // sample arriving mid-word is held until the stop
        fork
            chk_bytes(OFS_TEMP_MSB, 2, {16'hE780, 80'h0});
            begin
                wait (host_inst.got_n == 1);
                pulse_meas(32'h1A40_7E11);
            end
        join
        chk_bytes(OFS_TEMP_MSB, 6, {48'h1A40_0000_7E11, 48'h0});
        // every flag kind on some rx lane, thresholds hit exactly do not trip
        rx_power = {16'd150, 16'd1000, 16'd50, 16'd1500};
        tx_bias  = {16'd1500, 16'd50, 16'd900, 16'd100};
        repeat (4) @(negedge mclk);
        lanes_ok();
        chk_bytes(OFS_RX_FLAGS12, 4, {32'hA521_101A, 64'h0});
        chk_bytes(OFS_RX_FLAGS12, 4, {32'h0, 64'h0});
        // a persisting condition survives the read clear
        rx_power[0] = 16'd1500;
        repeat (4) @(negedge mclk);
        chk_bytes(OFS_RX_FLAGS12, 4, {32'hA000_0000, 64'h0});
        chk_bytes(OFS_RX_FLAGS12, 4, {32'hA000_0000, 64'h0});
        lanes_ok();
        chk_bytes(OFS_RX_FLAGS12, 1, {8'hA0, 88'h0});
        chk_bytes(OFS_RX_FLAGS12, 1, {8'h00, 88'h0});
        results();
    end

endmodule // dmm_monitor_map_tb

`default_nettype wire
